// File: hdl/sram_wr_pkg.sv
// constants for the synchronous burst sram write-control block
// assumes a single 40 MHz clock and pins synchronous to it
package sram_wr_pkg;
  localparam int BYTE_W = 9;
  localparam int NBYTE = 2;
  localparam int DATA_W = BYTE_W * NBYTE;
  localparam int ADDR_W = 16;
  localparam int BYTE_A = 0;
  localparam int BYTE_B = 1;
  localparam logic [NBYTE-1:0] BE_NONE = 2'h0;
  localparam logic [NBYTE-1:0] BE_ALL = 2'h3;
  // cycle kind, gray along idle -> read -> write
  typedef enum logic [1:0] {
    CYC_IDLE = 2'h0,
    CYC_READ = 2'h1,
    CYC_WRITE = 2'h3
  } cycle_t;
endpackage

// File: hdl/sync_sram_write_control.sv
// write decode, chip-enable qualification and output-enable gating of a 64K x 18 sync sram
// assumes the controller drives all inputs synchronously to ref_clk; data pins resolved outside
`timescale 1ns/100ps

module sync_sram_write_control
  import sram_wr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [sram_wr_pkg::ADDR_W-1:0] addr,
  input wire logic global_write_n,
  input wire logic write_qualifier_n,
  input wire logic byte_a_select_n,
  input wire logic byte_b_select_n,
  input wire logic select_one_n,
  input wire logic select_two,
  input wire logic select_three_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic output_enable_n,
  input wire logic [sram_wr_pkg::DATA_W-1:0] data_io_byte_in,
  output logic [sram_wr_pkg::DATA_W-1:0] data_io_byte_out,
  output logic [sram_wr_pkg::NBYTE-1:0] data_io_byte_oe,
  output logic chip_enabled_q,
  output logic [sram_wr_pkg::NBYTE-1:0] byte_write_q,
  output logic [1:0] cycle_q
);
  import sram_wr_pkg::*;

  // byte enables from the write pins; empty means read
  function automatic logic [NBYTE-1:0] write_decode(input logic gw_n, input logic sw_n,
                                                   input logic ba_n, input logic bb_n);
    logic [NBYTE-1:0] be;
    be = BE_NONE;
    if (!gw_n)
      be = BE_ALL;
    else if (!sw_n)
      be = {~bb_n, ~ba_n};
    return be;
  endfunction

  logic [NBYTE-1:0] be_d;
  logic strobe;
  logic enable_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] wmask;
  cycle_t cyc;

  assign be_d = write_decode(global_write_n, write_qualifier_n, byte_a_select_n, byte_b_select_n);
  assign strobe = !processor_addr_strobe_n || !controller_addr_strobe_n;
  assign enable_d = strobe && !select_one_n && select_two && !select_three_n;
  assign wmask = {{BYTE_W{byte_write_q[BYTE_B]}}, {BYTE_W{byte_write_q[BYTE_A]}}};
  assign cyc = cycle_t'(cycle_q);

  // rising edge reference
  // new enable only taken on a strobe; without one the held enable picks idle or a cycle kind decoded from the write pins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      chip_enabled_q <= 1'b0;
      byte_write_q <= BE_NONE;
      cycle_q <= CYC_IDLE;
      addr_q <= '0;
      wdata_q <= '0;
    end
    else if (clk_en)
    begin
      if (strobe)
        chip_enabled_q <= enable_d;
      byte_write_q <= (strobe && !enable_d) ? BE_NONE : be_d;
      addr_q <= addr;
      wdata_q <= data_io_byte_in;
      if (strobe && !enable_d)
        cycle_q <= CYC_IDLE;
      else if (strobe || chip_enabled_q)
        cycle_q <= (be_d != BE_NONE) ? CYC_WRITE : CYC_READ;
      else
        cycle_q <= CYC_IDLE;
    end
  end

  // late write into the array, masked per byte; array has no reset on purpose
  always_ff @(posedge ref_clk)
  begin
    if (clk_en && cyc == CYC_WRITE)
      mem[addr_q] <= (mem[addr_q] & ~wmask) | (wdata_q & wmask);
  end

  // pipelined read data register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      rdata_q <= '0;
    else if (clk_en && cyc == CYC_READ)
      rdata_q <= mem[addr_q];
  end

  // ignore enable in writes
  // sampled enable keeps the output registered; a true async gate lives in the pad
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      data_io_byte_oe <= BE_NONE;
      data_io_byte_out <= '0;
    end
    else if (clk_en)
    begin
      data_io_byte_out <= rdata_q;
      data_io_byte_oe <= (!output_enable_n && cyc != CYC_WRITE && be_d == BE_NONE) ? BE_ALL : BE_NONE;
    end
  end

  // global write request seen on the pins, strobed or continuing
  sequence s_write_cmd;
    clk_en && !global_write_n;
  endsequence

  // strobe that passes the select qualification
  sequence s_enabled_cmd;
    clk_en && strobe && enable_d;
  endsequence

  // registered result of an all-byte write command
  sequence s_write_all_cycle;
    cycle_q == CYC_WRITE && byte_write_q == BE_ALL;
  endsequence

  // every check is disabled in reset, where every register but the unreset array is forced to zero anyway;
  // decode checks exclude a failed qualification, which blanks the byte enables
  // all bytes selected
  AST_GLOBAL_ALL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_write_cmd and !(strobe && !enable_d)) |=> byte_write_q == BE_ALL)
    else $error("global write did not select all bytes");
  AST_PRIORITY: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && !global_write_n && write_qualifier_n && strobe && enable_d |=> cycle_q == CYC_WRITE)
    else $error("global write lost priority");
  AST_BYTE_A: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && global_write_n && !write_qualifier_n && !byte_a_select_n && byte_b_select_n
    && !(strobe && !enable_d) |=> byte_write_q == 2'h1)
    else $error("byte a write decode wrong");
  AST_BYTE_B: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && global_write_n && !write_qualifier_n && byte_a_select_n && !byte_b_select_n
    && !(strobe && !enable_d) |=> byte_write_q == 2'h2)
    else $error("byte b write decode wrong");
  AST_READ: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && global_write_n && write_qualifier_n |=> byte_write_q == BE_NONE)
    else $error("read cycle wrote bytes");
  AST_WRITE_DEF: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && strobe && enable_d && global_write_n && !write_qualifier_n && !(byte_a_select_n && byte_b_select_n)
    |=> cycle_q == CYC_WRITE)
    else $error("write cycle not started");
  AST_ENABLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && strobe |=> chip_enabled_q == $past(enable_d))
    else $error("chip enable qualification wrong");
  AST_DESELECT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && strobe && !enable_d |=> cycle_q == CYC_IDLE && byte_write_q == BE_NONE)
    else $error("deselect did not end the cycle");
  AST_WRITE_STEP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_write_cmd and s_enabled_cmd) |=> s_write_all_cycle)
    else $error("all-byte write did not start");
  AST_OE_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && cyc == CYC_WRITE |=> data_io_byte_oe == BE_NONE)
    else $error("outputs driven during write");
  AST_OE_NEWWRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && be_d != BE_NONE |=> data_io_byte_oe == BE_NONE)
    else $error("outputs driven as a write begins");
  AST_OE_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && output_enable_n |=> data_io_byte_oe == BE_NONE)
    else $error("outputs driven with enable high");
  AST_OE_DRIVE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && !output_enable_n && cyc == CYC_READ && be_d == BE_NONE |=> data_io_byte_oe == BE_ALL)
    else $error("outputs not driven in read");
  AST_REG_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> addr_q == $past(addr))
    else $error("address not registered");
  AST_REG_DATA: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> wdata_q == $past(data_io_byte_in))
    else $error("write data not registered");
  AST_OUT_PIPE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> data_io_byte_out == $past(rdata_q))
    else $error("read data not launched on the edge");
  // a low clock enable must hold every control register, or a stalled controller loses its cycle
  // edge only when enabled
  AST_FREEZE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !clk_en |=> $stable(cycle_q) && $stable(byte_write_q) && $stable(chip_enabled_q) && $stable(data_io_byte_oe))
    else $error("state moved with clock enable low");
endmodule

// File: dv/sram_ctrl_model.sv
// controller-side model: output enable and data bus resolution
// assumes the block's per-byte drive enables are active high
`timescale 1ns/100ps
module sram_ctrl_model
  import sram_wr_pkg::*;
(
  input wire logic rd_en,
  input wire logic wr_drive,
  input wire logic [sram_wr_pkg::DATA_W-1:0] wdata,
  input wire logic [sram_wr_pkg::DATA_W-1:0] dev_out,
  input wire logic [sram_wr_pkg::NBYTE-1:0] dev_oe,
  output logic output_enable_n,
  output logic [sram_wr_pkg::DATA_W-1:0] bus
);
  assign output_enable_n = ~rd_en;
  // released lanes show the inverse so a stale value never matches
  always_comb
  begin
    bus = wr_drive ? wdata : ~wdata;
    for (int i = 0; i < NBYTE; i++)
      if (dev_oe[i])
        bus[i*BYTE_W +: BYTE_W] = dev_out[i*BYTE_W +: BYTE_W];
  end
endmodule

// File: dv/test_sync_sram_write_control.sv
// self-checking bench for the sram write-control block
// assumes the controller model resolves the shared data bus
`timescale 1ns/100ps
module test_sync_sram_write_control import sram_wr_pkg::*;;
  logic ref_clk = 0;
  logic rst_b = 0;
  logic en = 1;
  logic gw = 1, wq = 1, ba = 1, bb = 1, s1 = 0, s2 = 1, s3 = 0, ps = 1, cs = 1, rd = 0, wd = 0, oen, ce;
  logic [ADDR_W-1:0] addr = 16'h0;
  logic [DATA_W-1:0] wdata = 18'h0, bus, dout;
  logic [NBYTE-1:0] oe, bw;
  logic [1:0] cyc;
  int n_mismatch = 0, n_tests = 0, cyc_n = 0;
  // rows: write inputs, then expected byte enables
  logic [5:0] tbl [7] = '{6'h30, 6'h2C, 6'h25, 6'h2A, 6'h23, 6'h1F, 6'h07};
  logic [2:0] sel [4] = '{3'h6, 3'h0, 3'h3, 3'h2};
  sync_sram_write_control dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(en), .addr(addr),
    .global_write_n(gw), .write_qualifier_n(wq), .byte_a_select_n(ba), .byte_b_select_n(bb),
    .select_one_n(s1), .select_two(s2), .select_three_n(s3), .processor_addr_strobe_n(ps),
    .controller_addr_strobe_n(cs), .output_enable_n(oen), .data_io_byte_in(bus),
    .data_io_byte_out(dout), .data_io_byte_oe(oe), .chip_enabled_q(ce), .byte_write_q(bw),
    .cycle_q(cyc));
  sram_ctrl_model ctrl_u (.rd_en(rd), .wr_drive(wd), .wdata(wdata), .dev_out(dout),
    .dev_oe(oe), .output_enable_n(oen), .bus(bus));
  always #12.5 ref_clk = ~ref_clk;
  // a hang is cut short well beyond the few dozen cycles needed
  always @(posedge ref_clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 2000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one strobed command; returns just after its taking edge with the strobe
  // still low, so back-to-back commands never toggle it within one step
  task automatic cmd(input logic [3:0] w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    {gw, wq, ba, bb} = w;
    addr = a;
    wdata = d;
    wd = !(w[3] && w[2]);
    cs = 0;
    tick(1);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    tick(4);
    chk("rst", 18'({cyc, bw, ce, oe}), 18'h0);
    rst_b = 1;
    for (int i = 0; i < 7; i++)
    begin
      cmd(tbl[i][5:2], 16'(i), 18'(i));
      chk("dec", 18'({cyc, bw}), 18'({(tbl[i][1:0] != 2'h0) ? CYC_WRITE : CYC_READ, tbl[i][1:0]}));
    end
    cmd(4'h7, 16'h0041, 18'h2AB55);
    cmd(4'h9, 16'h0041, 18'h15ACA);
    cmd(4'hF, 16'h0041, 18'h0);
    rd = 1;
    tick(3);
    chk("rdata", dout, {9'h155, 9'h0CA});
    chk("oe_on", 18'(oe), 18'(BE_ALL));
    rd = 0;
    tick(2);
    chk("oe_off", 18'(oe), 18'(BE_NONE));
    // enable ignored once the write has begun; raised only after it starts
    cmd(4'h7, 16'h0042, 18'h3FFFF);
    rd = 1;
    tick(1);
    chk("oe_wr", 18'(oe), 18'(BE_NONE));
    rd = 0;
    cmd(4'hF, 16'h0, 18'h0);
    for (int k = 0; k < 4; k++)
    begin
      {s1, s2, s3} = sel[k];
      {ps, cs} = (k == 3) ? 2'h1 : 2'h2;
      tick(1);
      chk("sel", 18'({cyc, ce}), (k == 3) ? 18'({CYC_READ, 1'b1}) : 18'h0);
    end
    // clock enable low: a strobed write must leave the read state untouched
    en = 0;
    cmd(4'h0, 16'h0043, 18'h00001);
    tick(1);
    chk("freeze", 18'({cyc, bw, ce}), 18'({CYC_READ, BE_NONE, 1'b1}));
    // mid-run reset with a write pending on the pins
    en = 1;
    rst_b = 0;
    tick(1);
    chk("rst2", 18'({cyc, bw, ce, oe}), 18'h0);
    tally_and_finish();
  end
endmodule
